/* hdl/tec_channel.sv */
// tec_channel: one 8-bit count register with compare match and overflow
// assumes tick is a one-cycle count clock pulse in the clk_sys domain
`timescale 1ns/1ps
`default_nettype none
module tec_channel (
    // clock and reset
    input  wire logic            clk_sys,
    input  wire logic            reset,
    // control
    input  wire logic            run,
    input  wire logic            pwm,
    input  wire logic            tick,
    input  wire tec_pkg::tec_byte_t compare,
    // status
    output var  tec_pkg::tec_byte_t count_reg,
    output var  logic            match_reg,
    output var  logic            overflow_reg
);
    import tec_pkg::*;

    logic hit;
    assign hit = (count_reg == compare);

    // count register: cleared while stopped, cleared on match outside pwm
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            count_reg <= 8'h00;
        end else if (!run) begin
            count_reg <= 8'h00;
        end else if (tick) begin
            if (!pwm && hit) begin
                count_reg <= 8'h00;
            end else begin
                count_reg <= count_reg + 8'h01;
            end
        end
    end

    // one-cycle match and overflow pulses on the counting tick
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            match_reg    <= 1'b0;
            overflow_reg <= 1'b0;
        end else begin
            match_reg    <= run && tick && hit;
            overflow_reg <= run && tick && pwm && (count_reg == 8'hff);
        end
    end
endmodule : tec_channel
`default_nettype wire

/* hdl/tec_timer_pair.sv */
// tec_timer_pair: two 8-bit timers, timer0 also an event counter, with cpu-mapped registers
// assumes cpu strobes and the event pin are synchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
`include "tec_cfg.svh"
// Behaviour
// - run bit 7 low clears and stops the counter; high starts counting
// - mode bit 6: 0 clear on compare match, 1 free-running pwm
// - timer0 set/clear pair: 00 keep, 01 clear, 10 set, 11 prohibited
// - set/clear pair acts only outside pwm mode
// - set/clear bits always read back as zero
// - bit 1: inversion enable outside pwm, output polarity inside pwm
// - output enable bit 0 low forces timer output low
// - clearing run in pwm mode forces the pulse inactive
// - output settings reach the pin even while stopped
// - pin0 direction bit: 0 output buffer on, 1 input; resets to ff
// - compare match outside pwm clears counter, counting continues, match request raised
// - event mode counts event pin falling (select 0) or rising (select 1)
// - toggle on each match gives a 50 percent square wave
module tec_timer_pair (
    // clock and reset
    input  wire logic            clk_sys,
    input  wire logic            reset,
    // cpu memory access
    input  wire logic [15:0]     cpu_addr,
    input  wire logic            cpu_wr,
    input  wire logic            cpu_rd,
    input  wire tec_pkg::tec_byte_t cpu_wdata,
    output var  tec_pkg::tec_byte_t cpu_rdata,
    // shared pin
    input  wire logic            t0_event_pin,
    input  wire logic            pin0_latch,
    output var  logic            t0_out_pin,
    output var  logic            pin0_oe,
    // match requests
    output var  logic            t0_match_irq,
    output var  logic            t1_match_irq
);
    import tec_pkg::*;

    tec_byte_t   port5_direction_reg;
    tec_byte_t   timer0_mode_control_reg;
    tec_byte_t   timer1_mode_control_reg;
    tec_byte_t   t0_compare_reg;
    tec_byte_t   t1_compare_reg;
    tec_clksel_t t0_clock_select_reg;
    tec_clksel_t t1_clock_select_reg;
    logic [`TEC_PRESCALE_W-1:0] prescale_reg;
    logic        event_prev_reg;
    logic        out_ff_reg;
    logic        pwm_active_reg;
    logic        t0_tick;
    logic        t1_tick;
    logic        t0_match;
    logic        t1_match;
    logic        t0_overflow;
    logic        t0_run;
    logic        t1_run;
    logic        t0_pwm_select;
    logic        t1_pwm_select;
    logic        t0_invert_or_polarity;
    logic        t0_output_enable;
    logic        ctrl0_wr;
    logic        out_raw;
    tec_ff_cmd_t ff_cmd;
    tec_byte_t   t0_count;
    tec_byte_t   t1_count;

    // control fields
    assign t0_run                = timer0_mode_control_reg[`TEC_RUN_BIT];
    assign t1_run                = timer1_mode_control_reg[`TEC_RUN_BIT];
    assign t0_pwm_select         = timer0_mode_control_reg[`TEC_PWM_BIT];
    assign t1_pwm_select         = timer1_mode_control_reg[`TEC_PWM_BIT];
    assign t0_invert_or_polarity = timer0_mode_control_reg[`TEC_INV_POL_BIT];
    assign t0_output_enable      = timer0_mode_control_reg[`TEC_OE_BIT];
    assign ctrl0_wr              = cpu_wr && (cpu_addr == `TEC_ADDR_T0_CTRL);
    assign ff_cmd = tec_ff_cmd_t'({cpu_wdata[`TEC_FF_SET_BIT], cpu_wdata[`TEC_FF_CLEAR_BIT]});

    // register writes; set/clear bits are not stored
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            port5_direction_reg     <= `TEC_PORT5_DIR_RESET;
            timer0_mode_control_reg <= `TEC_CTRL_RESET;
            timer1_mode_control_reg <= `TEC_CTRL_RESET;
            t0_compare_reg          <= `TEC_COMPARE_RESET;
            t1_compare_reg          <= `TEC_COMPARE_RESET;
            t0_clock_select_reg     <= 3'h0;
            t1_clock_select_reg     <= 3'h0;
        end else if (cpu_wr) begin
            unique case (cpu_addr)
                `TEC_ADDR_PORT5_DIR: begin
                    port5_direction_reg <= (cpu_wdata & `TEC_PORT5_DIR_MASK) | 8'he6;
                end
                `TEC_ADDR_T0_CTRL: begin
                    timer0_mode_control_reg <= cpu_wdata & `TEC_T0_CTRL_MASK;
                end
                `TEC_ADDR_T1_CTRL: begin
                    timer1_mode_control_reg <= cpu_wdata & `TEC_T1_CTRL_MASK;
                end
                `TEC_ADDR_T0_COMPARE: t0_compare_reg <= cpu_wdata;
                `TEC_ADDR_T1_COMPARE: t1_compare_reg <= cpu_wdata;
                `TEC_ADDR_T0_CLKSEL: t0_clock_select_reg <= cpu_wdata[2:0];
                `TEC_ADDR_T1_CLKSEL: t1_clock_select_reg <= cpu_wdata[2:0];
                default: ;
            endcase
        end
    end

    // registered read data; unmapped addresses read zero
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cpu_rdata <= 8'h00;
        end else if (cpu_rd) begin
            unique case (cpu_addr)
                `TEC_ADDR_PORT5_DIR:  cpu_rdata <= port5_direction_reg & `TEC_PORT5_DIR_MASK;
                `TEC_ADDR_T0_CTRL:    cpu_rdata <= timer0_mode_control_reg;
                `TEC_ADDR_T1_CTRL:    cpu_rdata <= timer1_mode_control_reg;
                `TEC_ADDR_T0_COMPARE: cpu_rdata <= t0_compare_reg;
                `TEC_ADDR_T1_COMPARE: cpu_rdata <= t1_compare_reg;
                `TEC_ADDR_T0_CLKSEL:  cpu_rdata <= {5'h00, t0_clock_select_reg};
                `TEC_ADDR_T1_CLKSEL:  cpu_rdata <= {5'h00, t1_clock_select_reg};
                default:              cpu_rdata <= 8'h00;
            endcase
        end
    end

    // free-running prescaler and event pin history
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            prescale_reg   <= '0;
            event_prev_reg <= 1'b0;
        end else begin
            prescale_reg   <= prescale_reg + 1'b1;
            event_prev_reg <= t0_event_pin;
        end
    end

    // tick when the low k prescaler bits are all ones: divide by 2^k
    function automatic logic div_tick(input logic [`TEC_PRESCALE_W-1:0] p, input int k);
        logic [`TEC_PRESCALE_W-1:0] m;
        m = `TEC_PRESCALE_W'((1 << k) - 1);
        return (p & m) == m;
    endfunction

    // timer0 count clock, including event pin edges
    always_comb begin
        unique case (t0_clock_select_reg)
            3'h0: t0_tick = event_prev_reg && !t0_event_pin;
            3'h1: t0_tick = !event_prev_reg && t0_event_pin;
            3'h2: t0_tick = div_tick(prescale_reg, 1);
            3'h3: t0_tick = div_tick(prescale_reg, 2);
            3'h4: t0_tick = div_tick(prescale_reg, 4);
            3'h5: t0_tick = div_tick(prescale_reg, 6);
            3'h6: t0_tick = div_tick(prescale_reg, 8);
            3'h7: t0_tick = div_tick(prescale_reg, 13);
        endcase
    end

    // timer1 count clock; prohibited selections give no tick
    always_comb begin
        unique case (t1_clock_select_reg)
            3'h2:    t1_tick = div_tick(prescale_reg, 1);
            3'h3:    t1_tick = div_tick(prescale_reg, 5);
            3'h4:    t1_tick = div_tick(prescale_reg, 7);
            3'h5:    t1_tick = div_tick(prescale_reg, 10);
            3'h6:    t1_tick = div_tick(prescale_reg, 13);
            default: t1_tick = 1'b0;
        endcase
    end

    tec_channel u_t0 (
        .clk_sys      (clk_sys),
        .reset        (reset),
        .run          (t0_run),
        .pwm          (t0_pwm_select),
        .tick         (t0_tick),
        .compare      (t0_compare_reg),
        .count_reg    (t0_count),
        .match_reg    (t0_match),
        .overflow_reg (t0_overflow)
    );

    tec_channel u_t1 (
        .clk_sys      (clk_sys),
        .reset        (reset),
        .run          (t1_run),
        .pwm          (t1_pwm_select),
        .tick         (t1_tick),
        .compare      (t1_compare_reg),
        .count_reg    (t1_count),
        .match_reg    (t1_match),
        .overflow_reg ()
    );

    // timer0 output flip-flop: software set/clear, toggle on match
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            out_ff_reg <= 1'b0;
        end else if (ctrl0_wr && !cpu_wdata[`TEC_PWM_BIT]
                     && (ff_cmd == TEC_FF_SET || ff_cmd == TEC_FF_CLEAR)) begin
            // only a real set/clear write may override a match toggle
            unique case (ff_cmd)
                TEC_FF_CLEAR: out_ff_reg <= 1'b0;
                TEC_FF_SET:   out_ff_reg <= 1'b1;
                default:      out_ff_reg <= out_ff_reg;
            endcase
        end else if (t0_match && !t0_pwm_select && t0_invert_or_polarity) begin
            out_ff_reg <= !out_ff_reg;
        end
    end

    // pwm pulse: active from overflow to match, inactive when stopped
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pwm_active_reg <= 1'b0;
        end else if (!t0_run || !t0_pwm_select) begin
            pwm_active_reg <= 1'b0;
        end else if (t0_match) begin
            pwm_active_reg <= 1'b0;
        end else if (t0_overflow) begin
            pwm_active_reg <= 1'b1;
        end
    end

    // select flip-flop or polarised pulse, regardless of run
    assign out_raw = t0_pwm_select ? (pwm_active_reg ^ t0_invert_or_polarity)
                                   : out_ff_reg;

    // registered pin outputs and match requests
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            t0_out_pin   <= 1'b0;
            pin0_oe      <= 1'b0;
            t0_match_irq <= 1'b0;
            t1_match_irq <= 1'b0;
        end else begin
            t0_out_pin   <= (t0_output_enable && out_raw) | pin0_latch;
            pin0_oe      <= !port5_direction_reg[`TEC_PIN0_DIR_BIT];
            t0_match_irq <= t0_match && !t0_pwm_select;
            t1_match_irq <= t1_match && !t1_pwm_select;
        end
    end
endmodule : tec_timer_pair
`default_nettype wire

/* inc/tec_cfg.svh */
// tec_cfg.svh: addresses, field positions, reset values and prescaler width
// assumes a 16-bit cpu memory address and 8-bit data
`ifndef TEC_CFG_SVH
`define TEC_CFG_SVH

// register addresses
`define TEC_ADDR_PORT5_DIR   16'hff25
`define TEC_ADDR_T0_COMPARE  16'hff2d
`define TEC_ADDR_T0_CLKSEL   16'hff2e
`define TEC_ADDR_T0_CTRL     16'hff2f
`define TEC_ADDR_T1_COMPARE  16'hff3d
`define TEC_ADDR_T1_CLKSEL   16'hff3e
`define TEC_ADDR_T1_CTRL     16'hff3f

// mode control and pin direction field positions
`define TEC_RUN_BIT          7
`define TEC_PWM_BIT          6
`define TEC_FF_SET_BIT       3
`define TEC_FF_CLEAR_BIT     2
`define TEC_INV_POL_BIT      1
`define TEC_OE_BIT           0
`define TEC_PIN0_DIR_BIT     0

// writable masks
`define TEC_T0_CTRL_MASK     8'hc3
`define TEC_T1_CTRL_MASK     8'hc0
`define TEC_PORT5_DIR_MASK   8'h19
`define TEC_CLKSEL_MASK      8'h07

// reset values
`define TEC_PORT5_DIR_RESET  8'hff
`define TEC_CTRL_RESET       8'h00
`define TEC_COMPARE_RESET    8'h00
`define TEC_CLKSEL_RESET     8'h00

// prescaler width, enough for the longest division by 2^13
`define TEC_PRESCALE_W       13
`endif

/* inc/tec_pkg.sv */
// tec_pkg: shared types of the timer/event counter block
// assumes tec_cfg.svh is on the include path
package tec_pkg;
    typedef logic [7:0]  tec_byte_t;
    typedef logic [2:0]  tec_clksel_t;
    typedef enum logic [1:0] {
        TEC_FF_KEEP,
        TEC_FF_CLEAR,
        TEC_FF_SET,
        TEC_FF_BAD
    } tec_ff_cmd_t;
endpackage : tec_pkg

/* sim/tb.sv */
// tb: self-checking bench for the timer pair
// assumes design, checker and event source compiled before it
`timescale 1ns/1ps
`default_nettype none
module tb;
    import tec_pkg::*;
    logic clk_sys = 1'b0, reset = 1'b1, cpu_wr = 1'b0, cpu_rd = 1'b0, pin0_latch = 1'b0;
    logic rise_req = 1'b0, fall_req = 1'b0, t0_event_pin, t0_out_pin, pin0_oe, q_prev = 1'b0;
    logic t0_match_irq, t1_match_irq;
    logic [15:0] cpu_addr = 16'h0000;
    tec_byte_t cpu_wdata = 8'h00, cpu_rdata;
    tec_byte_t cyc = 8'h00, cnt0 = 8'h00, n = 8'h00, last0 = 8'h00, gap0 = 8'h00;
    tec_byte_t last1 = 8'h00, gap1 = 8'h00, lastq = 8'h00, gapq = 8'h00;
    int mismatches = 0, compares = 0;
    // rows: address, written byte, expected readback
    logic [31:0] rows [11] = '{32'hff250000, 32'hff25ff19, 32'hff2f3800, 32'hff2f0703,
        32'hff2f0000, 32'hff3f3f00, 32'hff2da5a5, 32'hff2eff07, 32'hff3e0606,
        32'hff3d5a5a, 32'hff307700};
    tec_timer_pair u_dut (.clk_sys, .reset, .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata,
        .cpu_rdata, .t0_event_pin, .pin0_latch, .t0_out_pin, .pin0_oe, .t0_match_irq,
        .t1_match_irq);
    tec_event_src u_src (.clk_sys, .reset, .rise_req, .fall_req, .t0_event_pin);
    always #2 clk_sys = ~clk_sys;
    // cycle stamps of match pulses and pin changes
    always @(posedge clk_sys) begin
        cyc <= cyc + 8'h01;
        q_prev <= t0_out_pin;
        if (t0_match_irq === 1'b1) begin
            cnt0 <= cnt0 + 8'h01;
            gap0 <= cyc - last0;
            last0 <= cyc;
        end
        if (t1_match_irq === 1'b1) begin
            gap1 <= cyc - last1;
            last1 <= cyc;
        end
        if (t0_out_pin !== q_prev) begin
            gapq <= cyc - lastq;
            lastq <= cyc;
        end
    end
    task automatic check(input string what, input tec_byte_t seen, input tec_byte_t exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic idle(input int c);
        repeat (c) @(posedge clk_sys);
        #1;
    endtask : idle
    task automatic wr(input logic [15:0] a, input tec_byte_t d);
        @(posedge clk_sys) #1;
        cpu_addr = a;
        cpu_wdata = d;
        cpu_wr = 1'b1;
        @(posedge clk_sys) #1;
        cpu_wr = 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [15:0] a, input tec_byte_t e);
        @(posedge clk_sys) #1;
        cpu_addr = a;
        cpu_rd = 1'b1;
        @(posedge clk_sys) #1;
        cpu_rd = 1'b0;
        check("register readback", cpu_rdata, e);
    endtask : rd_chk
    task automatic pin_chk(input logic e);
        idle(4);
        check("timer pin", {7'h00, t0_out_pin}, {7'h00, e});
    endtask : pin_chk
    task automatic pulse(input logic up);
        @(posedge clk_sys) #1;
        rise_req = up;
        fall_req = !up;
        @(posedge clk_sys) #1;
        rise_req = 1'b0;
        fall_req = 1'b0;
        idle(5);
    endtask : pulse
    task automatic rst_vals;
        rd_chk(16'hff2f, 8'h00);
        rd_chk(16'hff2d, 8'h00);
        rd_chk(16'hff25, 8'h19);
        check("pin buffer", {7'h00, pin0_oe}, 8'h00);
        rd_chk(16'hff3f, 8'h00);
    endtask : rst_vals
    task automatic end_sim;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim
    initial begin
        #(4 * 20000);
        mismatches++;
        $display("watchdog expired");
        end_sim();
    end
    initial begin
        idle(10);
        reset = 1'b0;
        rst_vals();
        $display("test reset values done");
        foreach (rows[i]) begin
            wr(rows[i][31:16], rows[i][15:8]);
            rd_chk(rows[i][31:16], rows[i][7:0]);
        end
        $display("test register table done");
        wr(16'hff2d, 8'h03);
        wr(16'hff2e, 8'h02);
        wr(16'hff3d, 8'h01);
        wr(16'hff3e, 8'h02);
        wr(16'hff2f, 8'h80);
        wr(16'hff3f, 8'h80);
        idle(40);
        check("timer0 period", gap0, 8'h08);
        check("timer1 period", gap1, 8'h04);
        wr(16'hff2f, 8'h00);
        wr(16'hff3f, 8'h00);
        idle(4);
        n = cnt0;
        idle(30);
        check("stopped count", cnt0 - n, 8'h00);
        $display("test interval done");
        wr(16'hff25, 8'h01);
        wr(16'hff2d, 8'h00);
        for (int e = 0; e < 2; e++) begin
            wr(16'hff2e, 8'(e));
            wr(16'hff2f, 8'h80);
            n = cnt0;
            pulse(1'b1);
            check("after rise", cnt0 - n, 8'(e));
            pulse(1'b0);
            check("after fall", cnt0 - n, 8'h01);
            wr(16'hff2f, 8'h00);
        end
        $display("test event done");
        wr(16'hff25, 8'h00);
        idle(2);
        check("pin buffer on", {7'h00, pin0_oe}, 8'h01);
        wr(16'hff2f, 8'h01);
        wr(16'hff2f, 8'h09);
        pin_chk(1'b1);
        wr(16'hff2f, 8'h0d);
        pin_chk(1'b1);
        wr(16'hff2f, 8'h05);
        pin_chk(1'b0);
        wr(16'hff2f, 8'h08);
        pin_chk(1'b0);
        pin0_latch = 1'b1;
        pin_chk(1'b1);
        pin0_latch = 1'b0;
        wr(16'hff2d, 8'h03);
        wr(16'hff2e, 8'h02);
        wr(16'hff2f, 8'h02);
        wr(16'hff2f, 8'h03);
        wr(16'hff2f, 8'h83);
        idle(40);
        check("square half period", gapq, 8'h08);
        wr(16'hff2f, 8'h03);
        wr(16'hff2f, 8'h05);
        $display("test square wave done");
        wr(16'hff2f, 8'h41);
        pin_chk(1'b0);
        wr(16'hff2f, 8'h49);
        pin_chk(1'b0);
        wr(16'hff2f, 8'h01);
        pin_chk(1'b0);
        wr(16'hff2f, 8'h43);
        pin_chk(1'b1);
        n = cnt0;
        wr(16'hff2f, 8'hc3);
        idle(600);
        check("pwm requests", cnt0 - n, 8'h00);
        wr(16'hff2f, 8'h43);
        pin_chk(1'b1);
        $display("test pwm done");
        wr(16'hff2f, 8'h03);
        wr(16'hff2f, 8'h83);
        idle(5);
        reset = 1'b1;
        idle(3);
        reset = 1'b0;
        rst_vals();
        n = cnt0;
        idle(30);
        check("after mid-run reset", cnt0 - n, 8'h00);
        $display("test mid-run reset done");
        end_sim();
    end
endmodule : tb
`default_nettype wire

/* sim/tec_event_src.sv */
// tec_event_src: external event source on the shared timer pin
// assumes one edge request at a time, driven just after a clk_sys edge
`timescale 1ns/1ps
`default_nettype none
module tec_event_src (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // edge requests
    input wire logic rise_req,
    input wire logic fall_req,
    // event line
    output var logic t0_event_pin
);
    // line idles low, moves one edge per request
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            t0_event_pin <= 1'b0;
        end else if (rise_req) begin
            t0_event_pin <= 1'b1;
        end else if (fall_req) begin
            t0_event_pin <= 1'b0;
        end
    end
endmodule : tec_event_src
`default_nettype wire

/* sim/tec_timer_pair_asserts.sv */
// tec_timer_pair_asserts: port-level checks of the timer pair
// assumes bind onto tec_timer_pair, cfg header on the include path
`timescale 1ns/1ps
`default_nettype none
`include "tec_cfg.svh"
module tec_timer_pair_asserts (
    // clock and reset
    input wire logic               clk_sys,
    input wire logic               reset,
    // cpu memory access
    input wire logic [15:0]        cpu_addr,
    input wire logic               cpu_wr,
    input wire logic               cpu_rd,
    input wire tec_pkg::tec_byte_t cpu_wdata,
    input wire tec_pkg::tec_byte_t cpu_rdata,
    // pin and match requests
    input wire logic               pin0_latch,
    input wire logic               t0_out_pin,
    input wire logic               pin0_oe,
    input wire logic               t0_match_irq,
    input wire logic               t1_match_irq
);
    import tec_pkg::*;
    tec_byte_t c0_reg;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // shadow of the last byte written to timer0 control
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            c0_reg <= 8'h00;
        end else if (cpu_wr && cpu_addr == `TEC_ADDR_T0_CTRL) begin
            c0_reg <= cpu_wdata;
        end
    end
    a_irq0_one_cycle: assert property (t0_match_irq |=> !t0_match_irq)
        else $error("timer0 match request longer than one cycle");
    a_irq1_one_cycle: assert property (t1_match_irq |=> !t1_match_irq)
        else $error("timer1 match request longer than one cycle");
    a_stop_no_irq: assert property ((!c0_reg[7]) [*4] |-> !t0_match_irq)
        else $error("timer0 match request while stopped");
    a_pwm_no_irq: assert property (c0_reg[6] [*4] |-> !t0_match_irq)
        else $error("timer0 match request in pwm mode");
    a_ff_bits_zero: assert property (cpu_rd && cpu_addr == `TEC_ADDR_T0_CTRL
        |=> cpu_rdata[5:2] == 4'h0) else $error("timer0 control set/clear bits read nonzero");
    a_oe_from_dir: assert property (cpu_wr && cpu_addr == `TEC_ADDR_PORT5_DIR
        |-> ##2 pin0_oe == !$past(cpu_wdata[0], 2)) else $error("pin buffer not per direction");
    a_out_disabled: assert property ((!c0_reg[0] && !pin0_latch) [*3] |-> !t0_out_pin)
        else $error("timer pin high with output disabled");
    a_pwm_stop_level: assert property ((c0_reg[6] && c0_reg[0] && !c0_reg[7]
        && !pin0_latch) [*3] |-> t0_out_pin == c0_reg[1])
        else $error("stopped pwm output not at inactive level");
endmodule : tec_timer_pair_asserts
bind tec_timer_pair tec_timer_pair_asserts u_chk (.clk_sys, .reset, .cpu_addr, .cpu_wr,
    .cpu_rd, .cpu_wdata, .cpu_rdata, .pin0_latch, .t0_out_pin, .pin0_oe, .t0_match_irq,
    .t1_match_irq);
`default_nettype wire
